// ===== hw/io_register_map_pin_priority.v
// Operation
// R1: any reset leaves every shared pin a plain input port
// R2: pin 0 owner order: analog 0, timer channel 0, keypad 0, general io
// R3: pin 1 owner order: analog 1, timer channel 1, keypad 1, general io
// R4: pin 2 owner order: external interrupt, keypad 2, timer clock, general input
// R5: pin 3 owner order: external reset, keypad 3, general io
// R6: pin 4 owner order: oscillator output, analog 2, keypad 4, general io
// R7: pin 5 owner order: oscillator input, analog 3, keypad 5, general io
// R8: decoder presents a 64 kilobyte space to the core
// R9: most registers in 0x0000-0x003f, rest individually in high pages
// R10: software avoids unimplemented and reserved locations
// R11: each configuration register takes only the first write after reset
// R12: reset pin enable cleared by power-on reset only
// R13: low voltage trip select cleared by power-on reset only
`timescale 1ns/1ps
`include "io_regmap_defs.vh"
module io_register_map_pin_priority (
   // clock and resets
   input wire clk_i,
   input wire rst_n_i,
   input wire por_n_i,
   // core access
   input wire [15:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   output wire reg_sel_o,
   // status from units
   input wire [7:0] timer_count_low_i,
   input wire [1:0] osc_state_i,
   input wire [7:0] reset_cause_i,
   input wire [7:0] int_pend1_i,
   input wire [7:0] int_pend3_i,
   input wire keypad_flag_i,
   input wire ext_int_flag_i,
   input wire [1:0] timer_chan_flag_i,
   // function enables
   input wire [3:0] analog_ch_en_i,
   input wire [1:0] timer_chan_out_en_i,
   input wire timer_clk_sel_i,
   // port a pin owner codes, one-hot per pin
   output reg [3:0] pin0_owner_o,
   output reg [3:0] pin1_owner_o,
   output reg [3:0] pin2_owner_o,
   output reg [2:0] pin3_owner_o,
   output reg [3:0] pin4_owner_o,
   output reg [3:0] pin5_owner_o,
   // configuration outputs
   output wire [7:0] config_first_o,
   output wire [7:0] config_second_o,
   output wire [7:0] osc_trim_o,
   output wire [15:0] timer_modulo_o
);
   // one-hot owner codes: highest priority function first
   localparam [3:0] OWN_F1 = 4'b0001;
   localparam [3:0] OWN_F2 = 4'b0010;
   localparam [3:0] OWN_F3 = 4'b0100;
   localparam [3:0] OWN_IO = 4'b1000;

   reg [7:0] pta_pue_reg;
   reg [7:0] ptb_pue_reg;
   reg [7:0] kbd_sc_reg;
   reg [7:0] kbd_ie_reg;
   reg [7:0] ext_int_sc_reg;
   reg [7:0] cfg2_reg;
   reg [7:0] cfg1_reg;
   reg cfg2_done_reg;
   reg cfg1_done_reg;
   reg reset_pin_enable_reg;
   reg lvtrip_reg;
   reg [7:0] tmod_hi_reg;
   reg [7:0] tmod_lo_reg;
   reg [7:0] timer_chan0_status_control_reg;
   reg [7:0] timer_chan1_status_control_reg;
   reg [7:0] timer_channel_zero_hi_reg;
   reg [7:0] timer_channel_zero_lo_reg;
   reg [7:0] timer_channel_one_hi_reg;
   reg [7:0] timer_channel_one_lo_reg;
   reg [7:0] osc_trim_reg;
   reg [7:0] brk_aux_reg;
   reg [7:0] brk_flag_ctl_reg;
   reg [7:0] flash_ctl_reg;
   reg [7:0] brk_hi_reg;
   reg [7:0] brk_lo_reg;
   reg [7:0] brk_sc_reg;
   reg [7:0] flash_prot_reg;
   reg [7:0] stored_trim_reg;
   reg sw_break_reg;
   reg [7:0] rdata_next;

   // write strobe for one register address
   function wr_hit;
      input [15:0] a;
      input [15:0] target;
      input w;
      begin
         wr_hit = w && (a == target);
      end
   endfunction

   // 16 bit decode of single high registers, low page and 0xFE00-0xFE0F selected as blocks, no aliasing across the 64 kilobyte map
   assign reg_sel_o = ((addr_i & `LOW_PAGE_MASK) == `LOW_PAGE_BASE) || // R8 R9
                      (addr_i[15:4] == 12'hFE0) || (addr_i == `ADDR_FLASH_PROT) ||
                      (addr_i == `ADDR_STORED_TRIM) || (addr_i == `ADDR_WDOG_CTL);

   // power-on-only fields live under the power-on reset
   always @(posedge clk_i or negedge por_n_i) begin
      if (!por_n_i) begin
         reset_pin_enable_reg <= 1'b0; // R12
         lvtrip_reg <= 1'b0; // R13
      end else begin
         if (wr_hit(addr_i, `ADDR_CFG2, wr_i) && !cfg2_done_reg) begin
            reset_pin_enable_reg <= wdata_i[`BIT_RESET_PIN_ENABLE]; // R11 R12
         end
         if (wr_hit(addr_i, `ADDR_CFG1, wr_i) && !cfg1_done_reg) begin
            lvtrip_reg <= wdata_i[`BIT_LVTRIP]; // R11 R13
         end
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pta_pue_reg <= `RST_ZERO;
         ptb_pue_reg <= `RST_ZERO;
         kbd_sc_reg <= `RST_ZERO;
         kbd_ie_reg <= `RST_ZERO;
         ext_int_sc_reg <= `RST_ZERO;
         cfg2_reg <= `RST_ZERO;
         cfg1_reg <= `RST_ZERO;
         cfg2_done_reg <= 1'b0;
         cfg1_done_reg <= 1'b0;
      end else begin
         if (wr_hit(addr_i, `ADDR_PTA_PUE, wr_i)) begin
            pta_pue_reg <= wdata_i & `WMASK_PTA_PUE;
         end
         if (wr_hit(addr_i, `ADDR_PTB_PUE, wr_i)) begin
            ptb_pue_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_KBD_SC, wr_i)) begin
            kbd_sc_reg <= wdata_i & `WMASK_KBD_SC;
         end
         if (wr_hit(addr_i, `ADDR_KBD_IE, wr_i)) begin
            kbd_ie_reg <= wdata_i & `WMASK_KBD_IE;
         end
         if (wr_hit(addr_i, `ADDR_EXT_INT_SC, wr_i)) begin
            ext_int_sc_reg <= wdata_i & `WMASK_EXT_INT_SC;
         end
         // later writes are dropped until the next reset
         if (wr_hit(addr_i, `ADDR_CFG2, wr_i) && !cfg2_done_reg) begin
            cfg2_reg <= wdata_i & `WMASK_CFG2; // R11
            cfg2_done_reg <= 1'b1; // R11
         end
         if (wr_hit(addr_i, `ADDR_CFG1, wr_i) && !cfg1_done_reg) begin
            cfg1_reg <= wdata_i; // R11
            cfg1_done_reg <= 1'b1; // R11
         end
      end
   end

   // timer and oscillator trim bank kept apart so its reset values sit beside its writes
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tmod_hi_reg <= `RST_TMR_MOD;
         tmod_lo_reg <= `RST_TMR_MOD;
         timer_chan0_status_control_reg <= `RST_ZERO;
         timer_chan1_status_control_reg <= `RST_ZERO;
         timer_channel_zero_hi_reg <= `RST_ZERO;
         timer_channel_zero_lo_reg <= `RST_ZERO;
         timer_channel_one_hi_reg <= `RST_ZERO;
         timer_channel_one_lo_reg <= `RST_ZERO;
         osc_trim_reg <= `RST_OSC_TRIM;
      end else begin
         if (wr_hit(addr_i, `ADDR_TMR_MOD_HI, wr_i)) begin
            tmod_hi_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_TMR_MOD_LO, wr_i)) begin
            tmod_lo_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_TMR_SC0, wr_i)) begin
            timer_chan0_status_control_reg <= wdata_i & `WMASK_TIMER_CHAN0_STATUS_CONTROL;
         end
         if (wr_hit(addr_i, `ADDR_TMR_SC1, wr_i)) begin
            timer_chan1_status_control_reg <= wdata_i & `WMASK_TIMER_CHAN1_STATUS_CONTROL;
         end
         if (wr_hit(addr_i, `ADDR_TMR_CH0_HI, wr_i)) begin
            timer_channel_zero_hi_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_TMR_CH0_LO, wr_i)) begin
            timer_channel_zero_lo_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_TMR_CH1_HI, wr_i)) begin
            timer_channel_one_hi_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_TMR_CH1_LO, wr_i)) begin
            timer_channel_one_lo_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_OSC_TRIM, wr_i)) begin
            osc_trim_reg <= wdata_i;
         end
      end
   end

   // high page bank; break address values reset to zero although software must not rely on it
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         brk_aux_reg <= `RST_ZERO;
         brk_flag_ctl_reg <= `RST_ZERO;
         flash_ctl_reg <= `RST_ZERO;
         brk_hi_reg <= `RST_ZERO;
         brk_lo_reg <= `RST_ZERO;
         brk_sc_reg <= `RST_ZERO;
         flash_prot_reg <= `RST_ZERO;
         stored_trim_reg <= `RST_ZERO;
         sw_break_reg <= 1'b0;
      end else begin
         // software break flag: writing 0 to bit 1 clears it
         if (wr_hit(addr_i, `ADDR_BRK_STATE, wr_i) && !wdata_i[1]) begin
            sw_break_reg <= 1'b0;
         end
         if (wr_hit(addr_i, `ADDR_BRK_AUX, wr_i)) begin
            brk_aux_reg <= wdata_i & `WMASK_BRK_AUX;
         end
         if (wr_hit(addr_i, `ADDR_BRK_FLAG_CTL, wr_i)) begin
            brk_flag_ctl_reg <= {wdata_i[7], 7'h00};
         end
         if (wr_hit(addr_i, `ADDR_FLASH_CTL, wr_i)) begin
            flash_ctl_reg <= wdata_i & `WMASK_FLASH_CTL;
         end
         if (wr_hit(addr_i, `ADDR_BRK_ADDR_HI, wr_i)) begin
            brk_hi_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_BRK_ADDR_LO, wr_i)) begin
            brk_lo_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_BRK_SC, wr_i)) begin
            brk_sc_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_FLASH_PROT, wr_i)) begin
            flash_prot_reg <= wdata_i;
         end
         if (wr_hit(addr_i, `ADDR_STORED_TRIM, wr_i)) begin
            stored_trim_reg <= wdata_i;
         end
      end
   end

   // configuration views with the power-on-only bits merged in
   wire [7:0] cfg1_view = {cfg1_reg[7:4], lvtrip_reg, cfg1_reg[2:0]};
   wire [7:0] cfg2_view = {cfg2_reg[7:1], reset_pin_enable_reg};

   // read mux; unlisted and reserved addresses return zero
   always @* begin
      case (addr_i) // R9
         `ADDR_PTA_PUE: rdata_next = pta_pue_reg;
         `ADDR_PTB_PUE: rdata_next = ptb_pue_reg;
         `ADDR_KBD_SC: rdata_next = {4'h0, keypad_flag_i, 1'b0, kbd_sc_reg[1:0]};
         `ADDR_KBD_IE: rdata_next = kbd_ie_reg;
         `ADDR_EXT_INT_SC: rdata_next = {4'h0, ext_int_flag_i, 1'b0, ext_int_sc_reg[1:0]};
         `ADDR_CFG2: rdata_next = cfg2_view;
         `ADDR_CFG1: rdata_next = cfg1_view;
         `ADDR_TMR_CNT_LO: rdata_next = timer_count_low_i;
         `ADDR_TMR_MOD_HI: rdata_next = tmod_hi_reg;
         `ADDR_TMR_MOD_LO: rdata_next = tmod_lo_reg;
         `ADDR_TMR_SC0: rdata_next = {timer_chan_flag_i[0], timer_chan0_status_control_reg[6:0]};
         `ADDR_TMR_CH0_HI: rdata_next = timer_channel_zero_hi_reg;
         `ADDR_TMR_CH0_LO: rdata_next = timer_channel_zero_lo_reg;
         `ADDR_TMR_SC1: rdata_next = {timer_chan_flag_i[1], timer_chan1_status_control_reg[6:0]};
         `ADDR_TMR_CH1_HI: rdata_next = timer_channel_one_hi_reg;
         `ADDR_TMR_CH1_LO: rdata_next = timer_channel_one_lo_reg;
         `ADDR_OSC_STATE: rdata_next = {6'h00, osc_state_i};
         `ADDR_OSC_TRIM: rdata_next = osc_trim_reg;
         `ADDR_BRK_STATE: rdata_next = {6'h00, sw_break_reg, 1'b0};
         `ADDR_RST_CAUSE: rdata_next = reset_cause_i;
         `ADDR_BRK_AUX: rdata_next = brk_aux_reg;
         `ADDR_BRK_FLAG_CTL: rdata_next = brk_flag_ctl_reg;
         `ADDR_INT_PEND1: rdata_next = int_pend1_i;
         `ADDR_INT_PEND2: rdata_next = 8'h00;
         `ADDR_INT_PEND3: rdata_next = int_pend3_i;
         `ADDR_FLASH_CTL: rdata_next = flash_ctl_reg;
         `ADDR_BRK_ADDR_HI: rdata_next = brk_hi_reg;
         `ADDR_BRK_ADDR_LO: rdata_next = brk_lo_reg;
         `ADDR_BRK_SC: rdata_next = brk_sc_reg;
         `ADDR_FLASH_PROT: rdata_next = flash_prot_reg;
         `ADDR_STORED_TRIM: rdata_next = stored_trim_reg;
         // low voltage status and watchdog control decode but read back as zero
         default: rdata_next = 8'h00; // R10
      endcase
   end

   // registered read data, one cycle after rd_i
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= rdata_next;
      end
   end

   // function enable terms decoded from the bank
   wire irq_en = cfg2_reg[`BIT_IRQEN];
   wire osc_out_en = pta_pue_reg[`BIT_OSC2EN] || cfg2_reg[`BIT_OSCOPT1];
   wire osc_in_en = cfg2_reg[`BIT_OSCOPT1] || cfg2_reg[`BIT_OSCOPT0];
   wire tmr0_en = timer_chan0_status_control_reg[`BIT_TSC_MSA+1] || timer_chan0_status_control_reg[`BIT_TSC_MSA] ||
                  timer_chan0_status_control_reg[`BIT_TSC_ELSB] || timer_chan0_status_control_reg[`BIT_TSC_ELSA] ||
                  timer_chan_out_en_i[0];
   wire tmr1_en = timer_chan1_status_control_reg[`BIT_TSC_MSA] || timer_chan1_status_control_reg[`BIT_TSC_ELSB] ||
                  timer_chan1_status_control_reg[`BIT_TSC_ELSA] || timer_chan_out_en_i[1];

   // three-level priority pick, plain io when nothing claims the pin
   function [3:0] pick;
      input f1;
      input f2;
      input f3;
      begin
         if (f1) begin
            pick = OWN_F1;
         end else if (f2) begin
            pick = OWN_F2;
         end else if (f3) begin
            pick = OWN_F3;
         end else begin
            pick = OWN_IO;
         end
      end
   endfunction

   // next owner codes, one per pin
   reg [3:0] pin0_owner_next;
   reg [3:0] pin1_owner_next;
   reg [3:0] pin2_owner_next;
   reg [2:0] pin3_owner_next;
   reg [3:0] pin4_owner_next;
   reg [3:0] pin5_owner_next;

   // enables settle one clock before the pin changes hands, so no glitchy handover
   always @* begin
      pin0_owner_next = pick(analog_ch_en_i[0], tmr0_en, kbd_ie_reg[0]); // R2
      pin1_owner_next = pick(analog_ch_en_i[1], tmr1_en, kbd_ie_reg[1]); // R3
      pin2_owner_next = pick(irq_en, kbd_ie_reg[2], timer_clk_sel_i); // R4
      case ({reset_pin_enable_reg, kbd_ie_reg[3]}) // R5
         2'b10: pin3_owner_next = 3'b001;
         2'b11: pin3_owner_next = 3'b001;
         2'b01: pin3_owner_next = 3'b010;
         default: pin3_owner_next = 3'b100;
      endcase
      pin4_owner_next = pick(osc_out_en, analog_ch_en_i[2], kbd_ie_reg[4]); // R6
      pin5_owner_next = pick(osc_in_en, analog_ch_en_i[3], kbd_ie_reg[5]); // R7
   end

   // owners registered so the reset value is plain input on every pin
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin0_owner_o <= OWN_IO; // R1
         pin1_owner_o <= OWN_IO; // R1
         pin2_owner_o <= OWN_IO; // R1
         pin3_owner_o <= 3'b100; // R1
         pin4_owner_o <= OWN_IO; // R1
         pin5_owner_o <= OWN_IO; // R1
      end else begin
         pin0_owner_o <= pin0_owner_next;
         pin1_owner_o <= pin1_owner_next;
         pin2_owner_o <= pin2_owner_next;
         pin3_owner_o <= pin3_owner_next;
         pin4_owner_o <= pin4_owner_next;
         pin5_owner_o <= pin5_owner_next;
      end
   end

   assign config_first_o = cfg1_view;
   assign config_second_o = cfg2_view;
   assign osc_trim_o = osc_trim_reg;
   assign timer_modulo_o = {tmod_hi_reg, tmod_lo_reg};
endmodule // io_register_map_pin_priority

// ===== hw/io_regmap_defs.vh
`ifndef IO_REGMAP_DEFS_VH
`define IO_REGMAP_DEFS_VH
// low page decode
`define LOW_PAGE_MASK 16'hFFC0
`define LOW_PAGE_BASE 16'h0000
// low page registers
`define ADDR_PTA_PUE 16'h000B
`define ADDR_PTB_PUE 16'h000C
`define ADDR_KBD_SC 16'h001A
`define ADDR_KBD_IE 16'h001B
`define ADDR_EXT_INT_SC 16'h001D
`define ADDR_CFG2 16'h001E
`define ADDR_CFG1 16'h001F
`define ADDR_TMR_CNT_LO 16'h0022
`define ADDR_TMR_MOD_HI 16'h0023
`define ADDR_TMR_MOD_LO 16'h0024
`define ADDR_TMR_SC0 16'h0025
`define ADDR_TMR_CH0_HI 16'h0026
`define ADDR_TMR_CH0_LO 16'h0027
`define ADDR_TMR_SC1 16'h0028
`define ADDR_TMR_CH1_HI 16'h0029
`define ADDR_TMR_CH1_LO 16'h002A
`define ADDR_OSC_STATE 16'h0036
`define ADDR_OSC_TRIM 16'h0038
// high page registers
`define ADDR_BRK_STATE 16'hFE00
`define ADDR_RST_CAUSE 16'hFE01
`define ADDR_BRK_AUX 16'hFE02
`define ADDR_BRK_FLAG_CTL 16'hFE03
`define ADDR_INT_PEND1 16'hFE04
`define ADDR_INT_PEND2 16'hFE05
`define ADDR_INT_PEND3 16'hFE06
`define ADDR_FLASH_CTL 16'hFE08
`define ADDR_BRK_ADDR_HI 16'hFE09
`define ADDR_BRK_ADDR_LO 16'hFE0A
`define ADDR_BRK_SC 16'hFE0B
`define ADDR_LV_STATUS 16'hFE0C
`define ADDR_FLASH_PROT 16'hFFBE
`define ADDR_STORED_TRIM 16'hFFC0
`define ADDR_WDOG_CTL 16'hFFFF
// reset values
`define RST_ZERO 8'h00
`define RST_TMR_MOD 8'hFF
`define RST_OSC_TRIM 8'h80
// writable masks
`define WMASK_PTA_PUE 8'hBF
`define WMASK_KBD_SC 8'h03
`define WMASK_KBD_IE 8'h7F
`define WMASK_EXT_INT_SC 8'h03
`define WMASK_CFG2 8'hD9
`define WMASK_TIMER_CHAN0_STATUS_CONTROL 8'h7F
`define WMASK_TIMER_CHAN1_STATUS_CONTROL 8'h5F
`define WMASK_BRK_AUX 8'h01
`define WMASK_FLASH_CTL 8'h0F
// field positions
`define BIT_OSC2EN 7
`define BIT_RESET_PIN_ENABLE 0
`define BIT_LVTRIP 3
`define BIT_IRQEN 6
`define BIT_TSC_MSA 4
`define BIT_TSC_ELSB 3
`define BIT_TSC_ELSA 2
`define BIT_OSCOPT1 4
`define BIT_OSCOPT0 3
`endif

// ===== dv/io_regmap_assertions.sv
`timescale 1ns/1ps
module io_regmap_checker (
   // clock and resets
   input wire clk_i,
   input wire rst_n_i,
   input wire por_n_i,
   // core access
   input wire [15:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire reg_sel_o,
   // status and enables
   input wire [7:0] timer_count_low_i,
   input wire [3:0] analog_ch_en_i,
   input wire [1:0] timer_chan_out_en_i,
   input wire timer_clk_sel_i,
   // owners and configuration
   input wire [3:0] pin0_owner_o,
   input wire [3:0] pin1_owner_o,
   input wire [3:0] pin2_owner_o,
   input wire [2:0] pin3_owner_o,
   input wire [3:0] pin4_owner_o,
   input wire [3:0] pin5_owner_o,
   input wire [7:0] config_first_o,
   input wire [7:0] config_second_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   reg cfg1_done;
   reg cfg2_done;
   // write-once tracking, cleared by rst_n_i only, not by por_n_i
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg1_done <= 1'b0;
         cfg2_done <= 1'b0;
      end else begin
         if (wr_i && addr_i == 16'h001F) cfg1_done <= 1'b1;
         if (wr_i && addr_i == 16'h001E) cfg2_done <= 1'b1;
      end
   end
   sequence s_cfg1_first; wr_i && addr_i == 16'h001F && !cfg1_done; endsequence
   sequence s_cfg2_first; wr_i && addr_i == 16'h001E && !cfg2_done; endsequence
   sequence s_cfg1_again; wr_i && addr_i == 16'h001F && cfg1_done; endsequence
   property p_owner_rst;
      $rose(rst_n_i) |-> pin0_owner_o == 4'h8 && pin1_owner_o == 4'h8 && pin2_owner_o == 4'h8
         && pin3_owner_o == 3'h4 && pin4_owner_o == 4'h8 && pin5_owner_o == 4'h8;
   endproperty
   property p_pin0_timer; !analog_ch_en_i[0] && timer_chan_out_en_i[0] |=> pin0_owner_o == 4'h2;
   endproperty
   property p_pin1_analog; analog_ch_en_i[1] |=> pin1_owner_o == 4'h1; endproperty
   property p_pin2_clk; timer_clk_sel_i |=> pin2_owner_o != 4'h8; endproperty
   property p_pin4_analog; analog_ch_en_i[2] |=> pin4_owner_o[3:2] == 2'b00; endproperty
   property p_pin5_analog; analog_ch_en_i[3] |=> pin5_owner_o[3:2] == 2'b00; endproperty
   property p_cfg1_first; s_cfg1_first |=> config_first_o == $past(wdata_i); endproperty
   property p_cfg2_first;
      s_cfg2_first |=> (config_second_o & 8'hD9) == ($past(wdata_i) & 8'hD9);
   endproperty
   property p_cfg1_locked; s_cfg1_again |=> $stable(config_first_o); endproperty
   property p_por_clear;
      disable iff (1'b0) !por_n_i |-> !config_second_o[0] && !config_first_o[3];
   endproperty
   // a plain reset must not touch the power-on-only fields
   property p_rst_keep;
      disable iff (1'b0) !rst_n_i && por_n_i && $past(por_n_i)
         |-> $stable(config_second_o[0]) && $stable(config_first_o[3]);
   endproperty
   property p_sel_hit;
      addr_i == 16'h001F || addr_i == 16'hFE0C || addr_i == 16'hFFBE |-> reg_sel_o;
   endproperty
   property p_sel_miss; addr_i == 16'h8000 |-> !reg_sel_o; endproperty
   property p_rd_lat; rd_i && addr_i == 16'h0022 |=> rdata_o == $past(timer_count_low_i);
   endproperty
   a_owner_rst: assert property (p_owner_rst) else $error("owner not io after reset");
   a_pin0_timer: assert property (p_pin0_timer) else $error("pin0 timer owner");
   a_pin1_analog: assert property (p_pin1_analog) else $error("pin1 analog owner");
   a_pin2_clk: assert property (p_pin2_clk) else $error("pin2 clock owner");
   a_pin4_analog: assert property (p_pin4_analog) else $error("pin4 analog owner");
   a_pin5_analog: assert property (p_pin5_analog) else $error("pin5 analog owner");
   a_cfg1_first: assert property (p_cfg1_first) else $error("cfg1 first write");
   a_cfg2_first: assert property (p_cfg2_first) else $error("cfg2 first write");
   a_cfg1_locked: assert property (p_cfg1_locked) else $error("cfg1 rewritten");
   a_por_clear: assert property (p_por_clear) else $error("por fields not clear");
   a_rst_keep: assert property (p_rst_keep) else $error("por fields lost");
   a_sel_hit: assert property (p_sel_hit) else $error("register not decoded");
   a_sel_miss: assert property (p_sel_miss) else $error("stray decode");
   a_rd_lat: assert property (p_rd_lat) else $error("read data wrong");
endmodule // io_regmap_checker
bind io_register_map_pin_priority io_regmap_checker i_io_regmap_checker (.clk_i, .rst_n_i,
   .por_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .reg_sel_o, .timer_count_low_i,
   .analog_ch_en_i, .timer_chan_out_en_i, .timer_clk_sel_i, .pin0_owner_o, .pin1_owner_o,
   .pin2_owner_o, .pin3_owner_o, .pin4_owner_o, .pin5_owner_o, .config_first_o,
   .config_second_o);

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
   reg clk_i = 0, rst_n_i = 1, por_n_i = 1, wr_i = 0, rd_i = 0, timer_clk_sel_i = 0, rd_d = 0;
   reg keypad_flag_i = 0, ext_int_flag_i = 0;
   reg [15:0] addr_i = 0;
   reg [7:0] wdata_i = 0, timer_count_low_i = 0, reset_cause_i = 0, int_pend1_i = 0;
   reg [7:0] int_pend3_i = 0, d1, exp_r;
   reg [1:0] osc_state_i = 0, timer_chan_flag_i = 0, timer_chan_out_en_i = 0;
   reg [3:0] analog_ch_en_i = 0;
   reg [15:0] ra [0:6] = '{16'h000B, 16'h001A, 16'h0023, 16'h0024, 16'h0038, 16'hFE07, 16'h8000};
   reg [7:0] re [0:6] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h80, 8'h00, 8'h00};
   reg [15:0] wa [0:3] = '{16'h0023, 16'h0024, 16'h0038, 16'h000C};
   reg [7:0] dv [0:3];
   reg [31:0] r;
   wire [7:0] rdata_o, config_first_o, config_second_o, osc_trim_o;
   wire [15:0] timer_modulo_o;
   wire [3:0] pin0_owner_o, pin1_owner_o, pin2_owner_o, pin4_owner_o, pin5_owner_o;
   wire [2:0] pin3_owner_o;
   wire reg_sel_o;
   integer seed = 32'hc00d, errors = 0, total_checks = 0, cycles = 0, i;
   reg [7:0] exp_q [$];
   io_register_map_pin_priority i_io_register_map_pin_priority (.clk_i, .rst_n_i, .por_n_i,
      .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .reg_sel_o, .timer_count_low_i, .osc_state_i,
      .reset_cause_i, .int_pend1_i, .int_pend3_i, .keypad_flag_i, .ext_int_flag_i,
      .timer_chan_flag_i, .analog_ch_en_i, .timer_chan_out_en_i, .timer_clk_sel_i,
      .pin0_owner_o, .pin1_owner_o, .pin2_owner_o, .pin3_owner_o, .pin4_owner_o,
      .pin5_owner_o, .config_first_o, .config_second_o, .osc_trim_o, .timer_modulo_o);
   initial forever #4 clk_i = ~clk_i;
   task results;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // a hang cannot outlast this ceiling
   always @(posedge clk_i) begin
      rd_d <= rd_i;
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         results;
      end
   end
   // read data is valid the cycle after the sampling edge
   always @(negedge clk_i) begin
      if (rd_d) begin
         exp_r = exp_q.pop_front();
         `CHK("rdata", exp_r, rdata_o)
      end
   end
   task wr(input [15:0] a, input [7:0] d);
      @(posedge clk_i);
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task rd(input [15:0] a, input [7:0] e);
      exp_q.push_back(e);
      @(posedge clk_i);
      addr_i <= a; rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask
   function [3:0] pick(input a, input b, input c);
      pick = a ? 4'h1 : b ? 4'h2 : c ? 4'h4 : 4'h8;
   endfunction
   task own(input [3:0] e0, e1, e2, input [2:0] e3, input [3:0] e4, e5);
      repeat (2) @(posedge clk_i);
      #1;
      `CHK("pin0", e0, pin0_owner_o)
      `CHK("pin1", e1, pin1_owner_o)
      `CHK("pin2", e2, pin2_owner_o)
      `CHK("pin3", e3, pin3_owner_o)
      `CHK("pin4", e4, pin4_owner_o)
      `CHK("pin5", e5, pin5_owner_o)
   endtask
   task pulse(input p);
      @(posedge clk_i);
      rst_n_i <= 1'b0; por_n_i <= !p;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1; por_n_i <= 1'b1;
      #1;
   endtask
   initial begin
      rst_n_i <= 1'b0;
      por_n_i <= 1'b0;
      timer_count_low_i <= $random(seed);
      reset_cause_i <= $random(seed);
      int_pend1_i <= $random(seed);
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1; por_n_i <= 1'b1;
      own(4'h8, 4'h8, 4'h8, 3'h4, 4'h8, 4'h8);
      for (i = 0; i < 7; i++) rd(ra[i], re[i]);
      `CHK("sel miss", 1'b0, reg_sel_o)
      keypad_flag_i <= 1'b1;
      ext_int_flag_i <= 1'b1;
      osc_state_i <= 2'b11;
      timer_chan_flag_i <= 2'b11;
      rd(16'h001A, 8'h08);
      rd(16'h001D, 8'h08);
      rd(16'h0036, 8'h03);
      rd(16'h0025, 8'h80);
      rd(16'hFE01, reset_cause_i);
      rd(16'hFE04, int_pend1_i);
      `CHK("sel hit", 1'b1, reg_sel_o)
      rd(16'h0022, timer_count_low_i);
      wr(16'h8000, 8'hFF);
      rd(16'h8000, 8'h00);
      for (i = 0; i < 4; i++) begin
         dv[i] = $random(seed);
         wr(wa[i], dv[i]);
         rd(wa[i], dv[i]);
      end
      `CHK("modulo", {dv[0], dv[1]}, timer_modulo_o)
      `CHK("trim", dv[2], osc_trim_o)
      d1 = $random(seed) | 8'h08;
      wr(16'h001F, d1);
      wr(16'h001E, 8'h51);
      wr(16'h001F, ~d1);
      wr(16'h001E, 8'h00);
      rd(16'h001F, d1);
      `CHK("cfg2", 8'h51, config_second_o & 8'hD9)
      own(4'h8, 4'h8, 4'h1, 3'h1, 4'h1, 4'h1);
      pulse(1'b0);
      `CHK("trip", 1'b1, config_first_o[3])
      `CHK("reset_pin_enable", 8'h01, config_second_o & 8'hD9)
      wr(16'h001F, 8'h08);
      `CHK("cfg1 rearm", 8'h08, config_first_o)
      pulse(1'b1);
      `CHK("por trip", 1'b0, config_first_o[3])
      `CHK("por reset_pin_enable", 1'b0, config_second_o[0])
      wr(16'h001E, 8'h00);
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         @(posedge clk_i);
         analog_ch_en_i <= r[3:0]; timer_chan_out_en_i <= r[5:4]; timer_clk_sel_i <= r[6];
         wr(16'h000B, {r[7], 7'h00});
         wr(16'h001B, {2'b00, r[13:8]});
         own(pick(r[0], r[4], r[8]), pick(r[1], r[5], r[9]), pick(1'b0, r[10], r[6]),
            r[11] ? 3'h2 : 3'h4, pick(r[7], r[2], r[12]),
            pick(1'b0, r[3], r[13]));
      end
      repeat (3) @(posedge clk_i);
      results;
   end
endmodule // tb_top
